//--- core/iosr_defines.vh
`ifndef IOSR_DEFINES_VH
`define IOSR_DEFINES_VH
// register index map (byte address = 4 * index)
`define IOSR_REG_CTRL      8'h00
`define IOSR_REG_DIN_INV   8'h01
`define IOSR_REG_DOUT_INV  8'h02
`define IOSR_REG_STATUS    8'h03
`define IOSR_REG_IRQ_STAT  8'h04
`define IOSR_REG_IRQ_MASK  8'h05
`define IOSR_REG_RIN       8'h06
`define IOSR_REG_ROUT      8'h07
`define IOSR_REG_DIN_SEL   8'h10
`define IOSR_REG_DOUT_SEL  8'h18
`define IOSR_REG_RIN_SEL   8'h20
`define IOSR_REG_ROUT_SEL  8'h28
// control bits
`define IOSR_CTRL_SIM      0
`define IOSR_CTRL_COMMIT   1
// input function codes
`define IOSR_FN_NONE       8'h00
`define IOSR_FN_FREE       8'h01
`define IOSR_FN_OT_CLR     8'h0c
`define IOSR_FN_FW_LIM     8'h1c
`define IOSR_FN_RV_LIM     8'h1d
`define IOSR_FN_HOME_SNS   8'h1e
`define IOSR_FN_GP_IN_BASE 8'h40
`define IOSR_FN_EXT_ONE    8'h68
// output function codes
`define IOSR_FO_ALM_N      8'h82
`define IOSR_FO_MOVING     8'h86
`define IOSR_FO_OT_MON     8'h89
`define IOSR_FO_EXC_MON    8'h8e
`define IOSR_FO_HOME_END   8'h90
`define IOSR_FO_ABS_VALID  8'h91
`define IOSR_FO_PRST_SET   8'h92
`define IOSR_FO_FACT_SET   8'h93
`define IOSR_FO_BRAKE      8'h94
`define IOSR_FO_GP_OUT_BASE 8'hc0
// selector reset packs, entry 0 in low byte
`define IOSR_DIN_SEL_RST   48'h1d1c680c011e
`define IOSR_DOUT_SEL_RST  48'h82868e008990
`endif

//--- core/iosr_sync.v
`timescale 1ns/1ns
`default_nettype none
// two-stage synchroniser for pin levels
module iosr_sync #(
  parameter W = 6
) (
  input  wire         clk,
  input  wire         arst_n,
  input  wire [W-1:0] d,
  output wire [W-1:0] q
);
  reg [W-1:0] meta_ff;
  reg [W-1:0] sync_ff;
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_ff <= {W{1'b0}};
      sync_ff <= {W{1'b0}};
    end else begin
      meta_ff <= d;
      sync_ff <= meta_ff;
    end
  end
  assign q = sync_ff;
endmodule
`default_nettype wire

//--- core/iosr_irq.v
`timescale 1ns/1ns
`default_nettype none
// sticky event bits, write-one-to-clear, masked level irq
module iosr_irq #(
  parameter W = 8
) (
  input  wire         clk,
  input  wire         arst_n,
  input  wire [W-1:0] event_in,
  input  wire         clr_we,
  input  wire [W-1:0] clr_bits,
  input  wire         mask_we,
  input  wire [W-1:0] mask_wdata,
  output reg  [W-1:0] stat_ff,
  output reg  [W-1:0] mask_ff,
  output reg          irq_ff
);
  wire [W-1:0] clr = clr_we ? clr_bits : {W{1'b0}};
  // set wins over a clear in the same cycle
  wire [W-1:0] nxt_stat = (stat_ff & ~clr) | event_in;
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stat_ff <= {W{1'b0}};
      mask_ff <= {W{1'b0}};
      irq_ff  <= 1'b0;
    end else begin
      stat_ff <= nxt_stat;
      if (mask_we) begin
        mask_ff <= mask_wdata;
      end
      irq_ff <= |(nxt_stat & (mask_we ? mask_wdata : mask_ff));
    end
  end
endmodule
`default_nettype wire

//--- core/iosr_top.v
// The register addresses and strobed register access were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "iosr_defines.vh"
module iosr_top #(
  parameter NDIN  = 6,
  parameter NDOUT = 6,
  parameter NRIN  = 8,
  parameter NROUT = 8,
  parameter NGP   = 16
) (
  // clock and reset
  input  wire             CLOCK,
  input  wire             ARST_N,
  // register port
  input  wire [7:0]       REG_ADDR,
  input  wire [31:0]      REG_WDATA,
  input  wire             REG_WR,
  input  wire             REG_RD,
  output reg  [31:0]      REG_RDATA,
  output wire             IRQ,
  // direct pins
  input  wire [NDIN-1:0]  DIN_PINS,
  output reg  [NDOUT-1:0] DOUT_PINS,
  // drive core status, same clock
  input  wire             EXCITED,
  input  wire             BRAKE_RELEASE,
  input  wire             MOVING,
  input  wire             HOME_END,
  input  wire             OVERTRAVEL,
  input  wire             ALARM,
  input  wire             COORDS_SET,
  input  wire             HOME_SET,
  input  wire             FACTORY_HOME,
  input  wire             SENSOR_ERR_RAW,
  // drive core controls
  output reg              EXCITE_EN,
  output reg              BRAKE_RELEASE_EN,
  output reg              FREE_RUN,
  output reg              OVERTRAVEL_CLR,
  output reg              HOME_SENSOR,
  output reg              FORWARD_LIMIT,
  output reg              REVERSE_LIMIT,
  output reg              EXTERNAL_FUNC_ONE,
  output reg              SENSOR_ALARM,
  output reg              ABS_POSITION_VALID,
  output reg              PRESET_HOME_SET,
  output reg              FACTORY_HOME_SET
);
  localparam SW = 8;
  // working and shadow settings
  reg  [NDIN*SW-1:0]  din_sel_ff,  din_sel_sh_ff;
  reg  [NDOUT*SW-1:0] dout_sel_ff, dout_sel_sh_ff;
  reg  [NRIN*SW-1:0]  rin_sel_ff,  rin_sel_sh_ff;
  reg  [NROUT*SW-1:0] rout_sel_ff, rout_sel_sh_ff;
  reg  [NDIN-1:0]     din_inv_ff,  din_inv_sh_ff;
  reg  [NDOUT-1:0]    dout_inv_ff, dout_inv_sh_ff;
  reg                 sim_ff;
  reg  [NRIN-1:0]     rin_ff;
  reg  [NROUT-1:0]    rout_ff;
  reg                 alarm_d_ff;
  wire [NDIN-1:0]     din_s;
  wire [7:0]          irq_stat;
  wire [7:0]          irq_mask;
  wire                irq_lvl;

  iosr_sync #(.W(NDIN)) u_sync (
    .clk    (CLOCK),
    .arst_n (ARST_N),
    .d      (DIN_PINS),
    .q      (din_s)
  );

  // selector bank hit, shared by the write and read decode
  function in_bank;
    input [7:0] addr;
    input [7:0] base;
    input integer n;
    begin
      in_bank = (addr >= base) && (addr < base + n);
    end
  endfunction

  // register write decode
  wire wr_ctrl     = REG_WR && (REG_ADDR == `IOSR_REG_CTRL);
  wire commit      = wr_ctrl && REG_WDATA[`IOSR_CTRL_COMMIT];
  wire wr_din_inv  = REG_WR && (REG_ADDR == `IOSR_REG_DIN_INV);
  wire wr_dout_inv = REG_WR && (REG_ADDR == `IOSR_REG_DOUT_INV);
  wire wr_rin      = REG_WR && (REG_ADDR == `IOSR_REG_RIN);
  wire wr_irq_clr  = REG_WR && (REG_ADDR == `IOSR_REG_IRQ_STAT);
  wire wr_irq_mask = REG_WR && (REG_ADDR == `IOSR_REG_IRQ_MASK);
  wire wr_din_sel  = REG_WR && in_bank(REG_ADDR, `IOSR_REG_DIN_SEL, NDIN);
  wire wr_dout_sel = REG_WR && in_bank(REG_ADDR, `IOSR_REG_DOUT_SEL, NDOUT);
  wire wr_rin_sel  = REG_WR && in_bank(REG_ADDR, `IOSR_REG_RIN_SEL, NRIN);
  wire wr_rout_sel = REG_WR && in_bank(REG_ADDR, `IOSR_REG_ROUT_SEL, NROUT);

  // in simulation the applied map is frozen at reset defaults
  always @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      din_sel_ff     <= `IOSR_DIN_SEL_RST;
      din_sel_sh_ff  <= `IOSR_DIN_SEL_RST;
      dout_sel_ff    <= `IOSR_DOUT_SEL_RST;
      dout_sel_sh_ff <= `IOSR_DOUT_SEL_RST;
      rin_sel_ff     <= {NRIN*SW{1'b0}};
      rin_sel_sh_ff  <= {NRIN*SW{1'b0}};
      rout_sel_ff    <= {NROUT*SW{1'b0}};
      rout_sel_sh_ff <= {NROUT*SW{1'b0}};
      din_inv_ff     <= {NDIN{1'b0}};
      din_inv_sh_ff  <= {NDIN{1'b0}};
      dout_inv_ff    <= {NDOUT{1'b0}};
      dout_inv_sh_ff <= {NDOUT{1'b0}};
      sim_ff         <= 1'b0;
      rin_ff         <= {NRIN{1'b0}};
    end else begin
      if (wr_ctrl) begin
        sim_ff <= REG_WDATA[`IOSR_CTRL_SIM];
      end
      if (wr_din_inv) begin
        din_inv_sh_ff <= REG_WDATA[NDIN-1:0];
      end
      if (wr_dout_inv) begin
        dout_inv_sh_ff <= REG_WDATA[NDOUT-1:0];
      end
      if (wr_rin) begin
        rin_ff <= REG_WDATA[NRIN-1:0];
      end
      if (wr_din_sel) begin
        din_sel_sh_ff[(REG_ADDR - `IOSR_REG_DIN_SEL)*SW +: SW] <= REG_WDATA[SW-1:0];
      end
      if (wr_dout_sel) begin
        dout_sel_sh_ff[(REG_ADDR - `IOSR_REG_DOUT_SEL)*SW +: SW] <= REG_WDATA[SW-1:0];
      end
      if (wr_rin_sel) begin
        rin_sel_sh_ff[(REG_ADDR - `IOSR_REG_RIN_SEL)*SW +: SW] <= REG_WDATA[SW-1:0];
      end
      if (wr_rout_sel) begin
        rout_sel_sh_ff[(REG_ADDR - `IOSR_REG_ROUT_SEL)*SW +: SW] <= REG_WDATA[SW-1:0];
      end
      if (commit) begin
        din_sel_ff  <= din_sel_sh_ff;
        dout_sel_ff <= dout_sel_sh_ff;
        rin_sel_ff  <= rin_sel_sh_ff;
        rout_sel_ff <= rout_sel_sh_ff;
        din_inv_ff  <= din_inv_sh_ff;
        dout_inv_ff <= dout_inv_sh_ff;
      end
    end
  end

  // simulation ignores user mapping and uses defaults
  wire [NDIN*SW-1:0]  din_sel_a  = sim_ff ? `IOSR_DIN_SEL_RST : din_sel_ff;
  wire [NDOUT*SW-1:0] dout_sel_a = sim_ff ? `IOSR_DOUT_SEL_RST : dout_sel_ff;
  wire [NRIN*SW-1:0]  rin_sel_a  = sim_ff ? {NRIN*SW{1'b0}} : rin_sel_ff;
  wire [NROUT*SW-1:0] rout_sel_a = sim_ff ? {NROUT*SW{1'b0}} : rout_sel_ff;
  wire [NDIN-1:0]     din_inv_a  = sim_ff ? {NDIN{1'b0}} : din_inv_ff;
  wire [NDOUT-1:0]    dout_inv_a = sim_ff ? {NDOUT{1'b0}} : dout_inv_ff;

  wire [NDIN-1:0] din_lvl = din_s ^ din_inv_a;

  // is any input source assigned to function code fn and on
  function fn_hit;
    input [7:0]           fn;
    input [NDIN*SW-1:0]   dsel;
    input [NDIN-1:0]      dlvl;
    input [NRIN*SW-1:0]   rsel;
    input [NRIN-1:0]      rlvl;
    integer i;
    begin
      fn_hit = 1'b0;
      for (i = 0; i < NDIN; i = i + 1) begin
        if (dsel[i*SW +: SW] == fn && fn != `IOSR_FN_NONE && dlvl[i]) begin
          fn_hit = 1'b1;
        end
      end
      for (i = 0; i < NRIN; i = i + 1) begin
        if (rsel[i*SW +: SW] == fn && fn != `IOSR_FN_NONE && rlvl[i]) begin
          fn_hit = 1'b1;
        end
      end
    end
  endfunction

  // general-purpose inputs loop back to matching outputs
  wire [NGP-1:0] gp_lvl;
  genvar g;
  generate
    for (g = 0; g < NGP; g = g + 1) begin : g_gp
      localparam [31:0] GP_CODE = `IOSR_FN_GP_IN_BASE + g;
      assign gp_lvl[g] = fn_hit(GP_CODE[7:0], din_sel_a, din_lvl,
                                rin_sel_a, rin_ff);
    end
  endgenerate

  wire free_in = fn_hit(`IOSR_FN_FREE, din_sel_a, din_lvl, rin_sel_a, rin_ff);

  // reported levels; sim overrides these five status functions, not alarm, moving, overtravel or home end
  wire exc_mon   = sim_ff ? 1'b0 : EXCITED;
  wire brk_mon   = sim_ff ? 1'b0 : BRAKE_RELEASE;
  wire abs_val   = sim_ff ? 1'b1 : COORDS_SET;
  wire prst_set  = sim_ff ? 1'b0 : HOME_SET;
  wire fact_set  = sim_ff ? 1'b0 : FACTORY_HOME;

  // output function value by code
  function [0:0] fo_val;
    input [7:0]     fo;
    input [NGP-1:0] gp;
    input [8:0]     st;
    begin
      case (fo)
        `IOSR_FO_ALM_N:     fo_val = ~st[0];
        `IOSR_FO_MOVING:    fo_val = st[1];
        `IOSR_FO_OT_MON:    fo_val = st[2];
        `IOSR_FO_EXC_MON:   fo_val = st[3];
        `IOSR_FO_HOME_END:  fo_val = st[4];
        `IOSR_FO_ABS_VALID: fo_val = st[5];
        `IOSR_FO_PRST_SET:  fo_val = st[6];
        `IOSR_FO_FACT_SET:  fo_val = st[7];
        `IOSR_FO_BRAKE:     fo_val = st[8];
        default: begin
          if (fo >= `IOSR_FO_GP_OUT_BASE && fo < `IOSR_FO_GP_OUT_BASE + NGP) begin
            fo_val = gp[fo[3:0]];
          end else begin
            fo_val = 1'b0;
          end
        end
      endcase
    end
  endfunction

  wire [8:0] st_vec = {brk_mon, fact_set, prst_set, abs_val, HOME_END,
                       exc_mon, OVERTRAVEL, MOVING, ALARM};

  reg [NDOUT-1:0] nxt_dout;
  reg [NROUT-1:0] nxt_rout;
  integer k;
  always @* begin
    nxt_dout = {NDOUT{1'b0}};
    nxt_rout = {NROUT{1'b0}};
    for (k = 0; k < NDOUT; k = k + 1) begin
      nxt_dout[k] = fo_val(dout_sel_a[k*SW +: SW], gp_lvl, st_vec) ^ dout_inv_a[k];
    end
    for (k = 0; k < NROUT; k = k + 1) begin
      nxt_rout[k] = fo_val(rout_sel_a[k*SW +: SW], gp_lvl, st_vec);
    end
  end

  wire sens_alarm = SENSOR_ERR_RAW && !sim_ff;

  // interrupt events: sensor alarm, free-run, alarm rise
  wire [7:0] events = {5'h00, ALARM && !alarm_d_ff, free_in && !FREE_RUN, sens_alarm};
  iosr_irq #(.W(8)) u_irq (
    .clk        (CLOCK),
    .arst_n     (ARST_N),
    .event_in   (events),
    .clr_we     (wr_irq_clr),
    .clr_bits   (REG_WDATA[7:0]),
    .mask_we    (wr_irq_mask),
    .mask_wdata (REG_WDATA[7:0]),
    .stat_ff    (irq_stat),
    .mask_ff    (irq_mask),
    .irq_ff     (irq_lvl)
  );
  assign IRQ = irq_lvl;

  always @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      DOUT_PINS          <= {NDOUT{1'b0}};
      rout_ff            <= {NROUT{1'b0}};
      alarm_d_ff         <= 1'b0;
      EXCITE_EN          <= 1'b0;
      BRAKE_RELEASE_EN   <= 1'b0;
      FREE_RUN           <= 1'b0;
      OVERTRAVEL_CLR     <= 1'b0;
      HOME_SENSOR        <= 1'b0;
      FORWARD_LIMIT      <= 1'b0;
      REVERSE_LIMIT      <= 1'b0;
      EXTERNAL_FUNC_ONE  <= 1'b0;
      SENSOR_ALARM       <= 1'b0;
      ABS_POSITION_VALID <= 1'b0;
      PRESET_HOME_SET    <= 1'b0;
      FACTORY_HOME_SET   <= 1'b0;
    end else begin
      DOUT_PINS          <= nxt_dout;
      rout_ff            <= nxt_rout;
      alarm_d_ff         <= ALARM;
      // real motor stays de-energised and braked in simulation
      EXCITE_EN          <= !sim_ff && !free_in;
      BRAKE_RELEASE_EN   <= !sim_ff && !free_in;
      FREE_RUN           <= free_in;
      OVERTRAVEL_CLR     <= fn_hit(`IOSR_FN_OT_CLR, din_sel_a, din_lvl, rin_sel_a, rin_ff);
      HOME_SENSOR        <= fn_hit(`IOSR_FN_HOME_SNS, din_sel_a, din_lvl, rin_sel_a, rin_ff);
      FORWARD_LIMIT      <= fn_hit(`IOSR_FN_FW_LIM, din_sel_a, din_lvl, rin_sel_a, rin_ff);
      REVERSE_LIMIT      <= fn_hit(`IOSR_FN_RV_LIM, din_sel_a, din_lvl, rin_sel_a, rin_ff);
      EXTERNAL_FUNC_ONE  <= fn_hit(`IOSR_FN_EXT_ONE, din_sel_a, din_lvl, rin_sel_a, rin_ff);
      SENSOR_ALARM       <= sens_alarm;
      ABS_POSITION_VALID <= abs_val;
      PRESET_HOME_SET    <= prst_set;
      FACTORY_HOME_SET   <= fact_set;
    end
  end

  // read mux, data one cycle after the strobe
  reg [31:0] nxt_rdata;
  always @* begin
    nxt_rdata = 32'h00000000;
    if (REG_ADDR == `IOSR_REG_CTRL) begin
      nxt_rdata[`IOSR_CTRL_SIM] = sim_ff;
    end else if (REG_ADDR == `IOSR_REG_DIN_INV) begin
      nxt_rdata[NDIN-1:0] = din_inv_sh_ff;
    end else if (REG_ADDR == `IOSR_REG_DOUT_INV) begin
      nxt_rdata[NDOUT-1:0] = dout_inv_sh_ff;
    end else if (REG_ADDR == `IOSR_REG_STATUS) begin
      nxt_rdata[NDIN-1:0] = din_s;
      nxt_rdata[8 +: NDOUT] = DOUT_PINS;
    end else if (REG_ADDR == `IOSR_REG_IRQ_STAT) begin
      nxt_rdata[7:0] = irq_stat;
    end else if (REG_ADDR == `IOSR_REG_IRQ_MASK) begin
      nxt_rdata[7:0] = irq_mask;
    end else if (REG_ADDR == `IOSR_REG_RIN) begin
      nxt_rdata[NRIN-1:0] = rin_ff;
    end else if (REG_ADDR == `IOSR_REG_ROUT) begin
      nxt_rdata[NROUT-1:0] = rout_ff;
    end else if (in_bank(REG_ADDR, `IOSR_REG_DIN_SEL, NDIN)) begin
      nxt_rdata[SW-1:0] = din_sel_sh_ff[(REG_ADDR - `IOSR_REG_DIN_SEL)*SW +: SW];
    end else if (in_bank(REG_ADDR, `IOSR_REG_DOUT_SEL, NDOUT)) begin
      nxt_rdata[SW-1:0] = dout_sel_sh_ff[(REG_ADDR - `IOSR_REG_DOUT_SEL)*SW +: SW];
    end else if (in_bank(REG_ADDR, `IOSR_REG_RIN_SEL, NRIN)) begin
      nxt_rdata[SW-1:0] = rin_sel_sh_ff[(REG_ADDR - `IOSR_REG_RIN_SEL)*SW +: SW];
    end else if (in_bank(REG_ADDR, `IOSR_REG_ROUT_SEL, NROUT)) begin
      nxt_rdata[SW-1:0] = rout_sel_sh_ff[(REG_ADDR - `IOSR_REG_ROUT_SEL)*SW +: SW];
    end
  end

  always @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      REG_RDATA <= 32'h00000000;
    end else if (REG_RD) begin
      REG_RDATA <= nxt_rdata;
    end else begin
      REG_RDATA <= 32'h00000000;
    end
  end
endmodule
`default_nettype wire

//--- bench/iosr_top_sva.sv
`timescale 1ns/1ns
`default_nettype none
module iosr_top_chk #(
  parameter NDOUT = 6
) (
  // clock and reset
  input wire logic             CLOCK,
  input wire logic             ARST_N,
  // register port
  input wire logic [7:0]       REG_ADDR,
  input wire logic [31:0]      REG_WDATA,
  input wire logic             REG_WR,
  input wire logic             REG_RD,
  input wire logic [31:0]      REG_RDATA,
  // pins and drive core
  input wire logic [NDOUT-1:0] DOUT_PINS,
  input wire logic             COORDS_SET,
  input wire logic             HOME_SET,
  input wire logic             FACTORY_HOME,
  input wire logic             SENSOR_ERR_RAW,
  input wire logic             EXCITE_EN,
  input wire logic             BRAKE_RELEASE_EN,
  input wire logic             FREE_RUN,
  input wire logic             SENSOR_ALARM,
  input wire logic             ABS_POSITION_VALID,
  input wire logic             PRESET_HOME_SET,
  input wire logic             FACTORY_HOME_SET
);
  logic sim_q_ff;
  logic sim_q2_ff;
  // sim bit as software last wrote it; the delayed copy lines up with registered outputs
  always @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      sim_q_ff  <= 1'b0;
      sim_q2_ff <= 1'b0;
    end else begin
      if (REG_WR && REG_ADDR == 8'h00) begin
        sim_q_ff <= REG_WDATA[0];
      end
      sim_q2_ff <= sim_q_ff;
    end
  end
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!ARST_N);
  property p_abs_valid;
    ABS_POSITION_VALID == (sim_q2_ff || $past(COORDS_SET));
  endproperty
  a_abs_valid: assert property (p_abs_valid) else $error("abs valid wrong");
  property p_preset;
    PRESET_HOME_SET == (!sim_q2_ff && $past(HOME_SET));
  endproperty
  a_preset: assert property (p_preset) else $error("preset home wrong");
  property p_factory;
    FACTORY_HOME_SET == (!sim_q2_ff && $past(FACTORY_HOME));
  endproperty
  a_factory: assert property (p_factory) else $error("factory home wrong");
  property p_sens_alarm;
    SENSOR_ALARM == (!sim_q2_ff && $past(SENSOR_ERR_RAW));
  endproperty
  a_sens_alarm: assert property (p_sens_alarm) else $error("sensor alarm wrong");
  property p_sim_hold;
    sim_q2_ff |-> !EXCITE_EN && !BRAKE_RELEASE_EN;
  endproperty
  a_sim_hold: assert property (p_sim_hold) else $error("excited in sim");
  property p_free_off;
    FREE_RUN [*2] |-> !EXCITE_EN && !BRAKE_RELEASE_EN;
  endproperty
  a_free_off: assert property (p_free_off) else $error("excited in free run");
  property p_rd_idle;
    !$past(REG_RD) |-> REG_RDATA == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_rd_status;
    REG_RD && REG_ADDR == 8'h03 |=> REG_RDATA[8 +: NDOUT] == $past(DOUT_PINS);
  endproperty
  a_rd_status: assert property (p_rd_status) else $error("status pins wrong");
  property p_rd_unmapped;
    REG_RD && REG_ADDR == 8'h3f |=> REG_RDATA == 32'h0;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read nonzero");
endmodule
bind iosr_top iosr_top_chk #(.NDOUT(NDOUT)) chk (
  .CLOCK(CLOCK), .ARST_N(ARST_N), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
  .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .DOUT_PINS(DOUT_PINS),
  .COORDS_SET(COORDS_SET), .HOME_SET(HOME_SET), .FACTORY_HOME(FACTORY_HOME),
  .SENSOR_ERR_RAW(SENSOR_ERR_RAW), .EXCITE_EN(EXCITE_EN),
  .BRAKE_RELEASE_EN(BRAKE_RELEASE_EN), .FREE_RUN(FREE_RUN), .SENSOR_ALARM(SENSOR_ALARM),
  .ABS_POSITION_VALID(ABS_POSITION_VALID), .PRESET_HOME_SET(PRESET_HOME_SET),
  .FACTORY_HOME_SET(FACTORY_HOME_SET)
);
`default_nettype wire

//--- bench/iosr_core_model.sv
`timescale 1ns/1ns
`default_nettype none
module iosr_core_model (
  // clock and reset
  input  wire logic clk,
  input  wire logic arst_n,
  // commands from the block
  input  wire logic excite_en,
  input  wire logic brake_en,
  // physical state back
  output logic      excited_ff,
  output logic      brake_rel_ff
);
  // coils and brake lag their command by a cycle
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      excited_ff   <= 1'b0;
      brake_rel_ff <= 1'b0;
    end else begin
      excited_ff   <= excite_en;
      brake_rel_ff <= brake_en;
    end
  end
endmodule
`default_nettype wire

//--- bench/test_io_signal_routing_sim.sv
`timescale 1ns/1ns
`default_nettype none
`include "iosr_defines.vh"
module test_io_signal_routing_sim;
  logic        clock;
  logic        arst_n;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [5:0]  din;
  logic        home_end, moving, overtravel, alarm;
  logic        coords, home_set, fact_home, sens_err;
  wire  [31:0] rdata;
  wire  [5:0]  dout;
  wire         irq, excited, brake_rel, exc_en, brk_en, free_run, ot_clr;
  wire         home_sns, fw_lim, rv_lim, ext_one, sens_alm, abs_ok, prst_set, fact_set;
  integer      n_mismatch;
  integer      comparisons;
  integer      cycles;
  logic [31:0] rv;
  iosr_top uut (
    .CLOCK(clock), .ARST_N(arst_n), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(rdata), .IRQ(irq),
    .DIN_PINS(din), .DOUT_PINS(dout), .EXCITED(excited), .BRAKE_RELEASE(brake_rel),
    .MOVING(moving), .HOME_END(home_end), .OVERTRAVEL(overtravel), .ALARM(alarm),
    .COORDS_SET(coords), .HOME_SET(home_set), .FACTORY_HOME(fact_home),
    .SENSOR_ERR_RAW(sens_err), .EXCITE_EN(exc_en), .BRAKE_RELEASE_EN(brk_en),
    .FREE_RUN(free_run), .OVERTRAVEL_CLR(ot_clr), .HOME_SENSOR(home_sns),
    .FORWARD_LIMIT(fw_lim), .REVERSE_LIMIT(rv_lim), .EXTERNAL_FUNC_ONE(ext_one),
    .SENSOR_ALARM(sens_alm), .ABS_POSITION_VALID(abs_ok), .PRESET_HOME_SET(prst_set),
    .FACTORY_HOME_SET(fact_set)
  );
  iosr_core_model core (
    .clk(clock), .arst_n(arst_n), .excite_en(exc_en), .brake_en(brk_en),
    .excited_ff(excited), .brake_rel_ff(brake_rel)
  );
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic complete_run;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_mismatch = n_mismatch + 1;
      complete_run();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons = comparisons + 1;
    if (got !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd   <= 1'b0;
    #1 rv = rdata;
  endtask
  task automatic wait_n(input integer n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic t_defaults;
    for (int i = 0; i < 8; i++) begin
      rd(8'h20 + i[7:0]);
      chk(rv, 32'h0);
      if (i < 6) begin
        rd(8'h10 + i[7:0]);
        chk(rv, {24'h0, 8'(`IOSR_DIN_SEL_RST >> (8 * i))});
        rd(8'h18 + i[7:0]);
        chk(rv, {24'h0, 8'(`IOSR_DOUT_SEL_RST >> (8 * i))});
      end
    end
    rd(8'h01);
    chk(rv, 32'h0);
    rd(8'h02);
    chk(rv, 32'h0);
    rd(8'h3f);
    chk(rv, 32'h0);
    home_end   <= 1'b1;
    alarm      <= 1'b1;
    moving     <= 1'b1;
    overtravel <= 1'b1;
    din        <= 6'h3f;
    // free-run must ripple through the core model before the monitor pin drops
    wait_n(6);
    chk({26'h0, dout}, 32'h13);
    chk({home_sns, free_run, ot_clr, ext_one, fw_lim, rv_lim, exc_en, brk_en}, 32'hfc);
    din <= 6'h01;
    wait_n(4);
    chk({home_sns, free_run, ot_clr, ext_one, fw_lim, rv_lim}, 32'h20);
    rd(8'h03);
    chk({26'h0, rv[5:0]}, 32'h1);
    din        <= 6'h00;
    home_end   <= 1'b1;
    alarm      <= 1'b0;
    moving     <= 1'b0;
    overtravel <= 1'b0;
  endtask
  task automatic t_sim;
    coords    <= 1'b1;
    home_set  <= 1'b1;
    fact_home <= 1'b1;
    sens_err  <= 1'b1;
    wr(8'h02, 32'h3f);
    wr(8'h00, 32'h2);
    wait_n(4);
    chk({28'h0, abs_ok, prst_set, fact_set, sens_alm}, 32'hf);
    chk({31'h0, dout[0]}, 32'h0);
    coords <= 1'b0;
    wr(8'h00, 32'h3);
    wait_n(3);
    chk({28'h0, abs_ok, prst_set, fact_set, sens_alm}, 32'h8);
    chk({30'h0, exc_en, brk_en}, 32'h0);
    chk({31'h0, dout[0]}, 32'h1);
    din <= 6'h02;
    wait_n(4);
    chk({30'h0, free_run, dout[3]}, 32'h2);
    din      <= 6'h00;
    sens_err <= 1'b0;
    wr(8'h00, 32'h2);
    wait_n(3);
    chk({31'h0, dout[0]}, 32'h0);
    wr(8'h02, 32'h0);
    wr(8'h00, 32'h2);
    home_end <= 1'b0;
  endtask
  task automatic t_irq;
    wr(8'h04, 32'h7);
    wr(8'h05, 32'h2);
    din <= 6'h02;
    wait_n(5);
    chk({31'h0, irq}, 32'h1);
    rd(8'h04);
    chk(rv, 32'h2);
    wr(8'h04, 32'h2);
    wait_n(2);
    chk({31'h0, irq}, 32'h0);
    din <= 6'h00;
    wr(8'h05, 32'h0);
    wait_n(3);
    din <= 6'h02;
    wait_n(5);
    chk({31'h0, irq}, 32'h0);
    rd(8'h04);
    chk(rv, 32'h2);
    din <= 6'h00;
    wr(8'h04, 32'h2);
  endtask
  task automatic t_invert;
    wr(8'h01, 32'h1);
    wait_n(4);
    chk({31'h0, home_sns}, 32'h0);
    rd(8'h01);
    chk(rv, 32'h1);
    wr(8'h00, 32'h2);
    wait_n(4);
    chk({31'h0, home_sns}, 32'h1);
    wr(8'h01, 32'h0);
    wr(8'h00, 32'h2);
  endtask
  task automatic t_gp;
    for (int n = 0; n < 16; n++) begin
      wr(8'h20, 32'h40 + n);
      wr(8'h18, 32'hc0 + n);
      wr(8'h00, 32'h2);
      wr(8'h06, 32'h1);
      wait_n(3);
      chk({31'h0, dout[0]}, 32'h1);
      wr(8'h06, 32'h0);
      wait_n(3);
      chk({31'h0, dout[0]}, 32'h0);
    end
    wr(8'h11, 32'h41);
    wr(8'h29, 32'hc1);
    wr(8'h00, 32'h2);
    din <= 6'h02;
    wait_n(4);
    rd(8'h07);
    chk({31'h0, rv[1]}, 32'h1);
    din <= 6'h00;
    wait_n(4);
    rd(8'h07);
    chk({31'h0, rv[1]}, 32'h0);
    wr(8'h01, 32'h2);
    wr(8'h00, 32'h2);
    wait_n(4);
    rd(8'h07);
    chk({31'h0, rv[1]}, 32'h1);
  endtask
  initial begin
    n_mismatch  = 0;
    comparisons = 0;
    cycles      = 0;
    arst_n      = 1'b0;
    reg_addr    = 8'h00;
    reg_wdata   = 32'h0;
    reg_wr      = 1'b0;
    reg_rd      = 1'b0;
    din         = 6'h00;
    {home_end, moving, overtravel, alarm} = 4'h0;
    {coords, home_set, fact_home, sens_err} = 4'h0;
    repeat (12) @(posedge clock);
    arst_n <= 1'b1;
    t_defaults();
    t_sim();
    t_irq();
    t_invert();
    t_gp();
    complete_run();
  end
endmodule
`default_nettype wire
